// ### verilog/fec_dev.sv
// Flash end: erase, deep sleep and ID commands on the serial link.
// Runs on the system clock and oversamples select and serial clock.
`timescale 1ns/1ps
`default_nettype none
`include "fec_defs.svh"

module fec_dev
  import fec_pkg::*;
#(
  parameter logic [31:0] BE_CYC    = 32'(`FEC_BE_CYC),
  parameter logic [31:0] CE_CYC    = 32'(`FEC_CE_CYC),
  parameter logic [7:0]  MAKER_ID  = 8'h5a, // Arbitrary value
  parameter logic [7:0]  DEVICE_ID = 8'h3c  // Arbitrary value
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  fec_if.dev              bus,
  input  wire logic [4:0] protect_sel_i,
  input  wire logic       protect_complement_i,
  input  wire logic       hpm_set_i,
  output logic            cycle_active_flag_o,
  output logic            write_permit_latch_o,
  output logic            deep_sleep_o,
  output logic            high_perf_o,
  output logic            erase_start_o,
  output logic            erase_chip_o,
  output logic [5:0]      erase_block_o
);

  fec_dev_st_type s_q;
  fec_dev_st_type s_d;

  // ========================================================
  // Block protection: low three selects size, bit 3 picks bottom
  function automatic logic blk_prot(input logic [5:0] b,
                                    input logic [4:0] bp,
                                    input logic       cmp);
    logic [6:0] n;
    logic       hit;
    n   = (bp[2:0] == 3'd0) ? 7'd0 : 7'd1 << (bp[2:0] - 3'd1);
    hit = bp[3] ? ({1'b0, b} < n) : ({1'b0, b} >= 7'd64 - n);
    return hit ^ cmp;
  endfunction

  logic       cs_n;
  logic       csf;
  logic       csr;
  logic       skr;
  logic       skf;
  logic [3:0] din;
  logic [7:0] nop;
  logic       blocked;

  // ========================================================
  // Next-state logic
  always_comb begin
    s_d      = s_q;
    s_d.s1   = {bus.io, bus.sclk, bus.cs_n};
    s_d.s2   = s_q.s1;
    s_d.prev = s_q.s2[1:0];
    s_d.go   = 1'b0;
    cs_n = s_q.s2[0];
    din  = s_q.s2[5:2];
    csf  = s_q.prev[0] & ~cs_n;
    csr  = ~s_q.prev[0] & cs_n;
    skr  = s_q.s2[1] & ~s_q.prev[1] & ~cs_n;
    skf  = ~s_q.s2[1] & s_q.prev[1] & ~cs_n;
    nop  = {s_q.op[6:0], din[0]};
    // In deep sleep only the wake and reset pair pass; during an erase wake, sleep and erases are blocked
    blocked = (s_q.busy == BK_SLEEP) || (s_q.busy == BK_WAKE) ||
              (s_q.sleep && nop != `FEC_OP_WAKE &&
               nop != `FEC_OP_RST_EN && nop != `FEC_OP_RST) ||
              (s_q.cycle_active_flag && (nop == `FEC_OP_WAKE ||
               nop == `FEC_OP_SLEEP || nop == `FEC_OP_BLK ||
               nop == `FEC_OP_CHIP_A || nop == `FEC_OP_CHIP_B));

    // Self-timed activity runs to its end regardless of the link
    if (s_q.busy != BK_NONE) begin
      if (s_q.tmr <= 32'd1) begin
        if (s_q.busy == BK_ERASE) s_d.cycle_active_flag = 1'b0;
        if (s_q.busy == BK_SLEEP) s_d.sleep = 1'b1;
        s_d.busy = BK_NONE;
      end else begin
        s_d.tmr = s_q.tmr - 32'd1;
      end
    end

    if (hpm_set_i) s_d.hpm = 1'b1;

    // Select falling restarts decoding
    if (csf) begin
      s_d.ph  = PH_OP;
      s_d.cnt = 6'd0;
      s_d.w   = 3'd1;
    end

    // Rising serial clock: shift in, MSB first
    if (skr) begin
      case (s_q.ph)
        PH_OP: begin
          s_d.op  = nop;
          s_d.cnt = s_q.cnt + 6'd1;
          if (s_q.cnt == 6'(`FEC_OP_BITS - 1)) begin
            s_d.cnt = 6'd0;
            if (blocked) begin
              s_d.ph = PH_IGN;
            end else if (nop == `FEC_OP_BLK || nop == `FEC_OP_ID1) begin
              s_d.ph  = PH_ADR;
              s_d.len = 6'(`FEC_ADR_BITS);
            end else if (nop == `FEC_OP_ID2) begin
              s_d.ph  = PH_ADR;
              s_d.len = 6'(`FEC_ADR_BITS / 2);
              s_d.w   = 3'd2;
            end else if (nop == `FEC_OP_ID4) begin
              s_d.ph  = PH_ADR;
              s_d.len = 6'(`FEC_ADR_BITS / 4 + `FEC_ID4_DUMMY);
              s_d.w   = 3'd4;
            end else if (nop == `FEC_OP_CHIP_A || nop == `FEC_OP_CHIP_B ||
                         nop == `FEC_OP_SLEEP || nop == `FEC_OP_WAKE ||
                         nop == `FEC_OP_RST_EN || nop == `FEC_OP_RST ||
                         nop == `FEC_OP_WRITE_PERMIT_CMD) begin
              s_d.ph = PH_ARM;
            end else begin
              s_d.ph = PH_IGN;
            end
          end
        end
        PH_ADR: begin
          case (s_q.w)
            3'd4:    s_d.adr = {s_q.adr[19:0], din};
            3'd2:    s_d.adr = {s_q.adr[21:0], din[1:0]};
            default: s_d.adr = {s_q.adr[22:0], din[0]};
          endcase
          s_d.cnt = s_q.cnt + 6'd1;
          if (s_q.cnt == s_q.len - 6'd1) begin
            s_d.ph = (s_q.op == `FEC_OP_BLK) ? PH_ARM : PH_OUT;
            s_d.sh = (s_q.op == `FEC_OP_WAKE) ? {DEVICE_ID, DEVICE_ID}
                                               : {MAKER_ID, DEVICE_ID};
          end
        end
        PH_ARM: begin
          // Wake opcode may continue into three dummy bytes
          if (s_q.op == `FEC_OP_WAKE) begin
            s_d.ph  = PH_ADR;
            s_d.cnt = 6'd1;
            s_d.len = 6'(`FEC_ADR_BITS);
          end else begin
            s_d.ph = PH_IGN;
          end
        end
        default: ;
      endcase
    end

    // Falling serial clock: drive ID bits, rotate to repeat
    if (skf && s_q.ph == PH_OUT) begin
      case (s_q.w)
        3'd4: begin
          s_d.dq  = s_q.sh[15:12];
          s_d.doe = 4'hf;
          s_d.sh  = {s_q.sh[11:0], s_q.sh[15:12]};
        end
        3'd2: begin
          s_d.dq  = {2'b00, s_q.sh[15:14]};
          s_d.doe = 4'h3;
          s_d.sh  = {s_q.sh[13:0], s_q.sh[15:14]};
        end
        default: begin
          s_d.dq  = {2'b00, s_q.sh[15], 1'b0};
          s_d.doe = 4'h2;
          s_d.sh  = {s_q.sh[14:0], s_q.sh[15]};
        end
      endcase
    end

    // Select rising: run armed command, back to standby
    if (csr) begin
      s_d.ph  = PH_IDLE;
      s_d.doe = 4'h0;
      if (s_q.ph == PH_ARM) begin
        case (s_q.op)
          `FEC_OP_WRITE_PERMIT_CMD: s_d.write_permit_latch = 1'b1;
          `FEC_OP_BLK: begin
            if (s_q.write_permit_latch && !blk_prot(s_q.adr[`FEC_BLK_MSB:`FEC_BLK_LSB],
                protect_sel_i, protect_complement_i)) begin
              s_d.cycle_active_flag  = 1'b1;
              s_d.write_permit_latch  = 1'b0;
              s_d.busy = BK_ERASE;
              s_d.tmr  = BE_CYC;
              s_d.go   = 1'b1;
              s_d.chip = 1'b0;
              s_d.blk  = s_q.adr[`FEC_BLK_MSB:`FEC_BLK_LSB];
            end
          end
          `FEC_OP_CHIP_A, `FEC_OP_CHIP_B: begin
            if (s_q.write_permit_latch && ((protect_sel_i[2:0] == 3'd0 &&
                 !protect_complement_i) || (protect_sel_i[2:0] == 3'd7 &&
                 protect_complement_i))) begin
              s_d.cycle_active_flag  = 1'b1;
              s_d.write_permit_latch  = 1'b0;
              s_d.busy = BK_ERASE;
              s_d.tmr  = CE_CYC;
              s_d.go   = 1'b1;
              s_d.chip = 1'b1;
            end
          end
          `FEC_OP_SLEEP: begin
            s_d.busy = BK_SLEEP;
            s_d.tmr  = 32'(`FEC_DP_CYC);
          end
          `FEC_OP_WAKE: begin
            s_d.hpm = 1'b0;
            if (s_q.sleep) begin
              s_d.sleep = 1'b0;
              s_d.busy  = BK_WAKE;
              s_d.tmr   = 32'(`FEC_RES1_CYC);
            end
          end
          default: s_d.sleep = 1'b0;
        endcase
      end else if (s_q.ph == PH_OUT && s_q.op == `FEC_OP_WAKE) begin
        s_d.hpm = 1'b0;
        if (s_q.sleep) begin
          s_d.sleep = 1'b0;
          s_d.busy  = BK_WAKE;
          s_d.tmr   = 32'(`FEC_RES2_CYC);
        end
      end
    end
  end

  // ========================================================
  // State register; standby after reset, never asleep
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q      <= '0;
      s_q.s1   <= 6'h3d;                                  // Idle pin levels
      s_q.s2   <= 6'h3d;
      s_q.prev <= 2'b01;
      s_q.ph   <= PH_IDLE;
      s_q.w    <= 3'd1;
      s_q.busy <= BK_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================
  // Outputs straight from the state register
  assign bus.d_io             = s_q.dq;
  assign bus.d_oe             = s_q.doe;
  assign cycle_active_flag_o  = s_q.cycle_active_flag;
  assign write_permit_latch_o = s_q.write_permit_latch;
  assign deep_sleep_o         = s_q.sleep;
  assign high_perf_o          = s_q.hpm;
  assign erase_start_o        = s_q.go;
  assign erase_chip_o         = s_q.chip;
  assign erase_block_o        = s_q.blk;

endmodule

`default_nettype wire

// ### verilog/fec_defs.svh
// Constants of the flash erase / sleep / ID command block.
// Assumes a 40 MHz system clock on both ends of the serial link.
`ifndef FEC_DEFS_SVH
`define FEC_DEFS_SVH

// ==========================================================
// Opcodes
`define FEC_OP_WRITE_PERMIT_CMD    8'h06
`define FEC_OP_BLK     8'hd8
`define FEC_OP_CHIP_A  8'h60
`define FEC_OP_CHIP_B  8'hc7
`define FEC_OP_SLEEP   8'hb9
`define FEC_OP_WAKE    8'hab
`define FEC_OP_RST_EN  8'h66
`define FEC_OP_RST     8'h99
`define FEC_OP_ID1     8'h90
`define FEC_OP_ID2     8'h92
`define FEC_OP_ID4     8'h94

// ==========================================================
// Frame layout
`define FEC_OP_BITS    8
`define FEC_ADR_BITS   24
`define FEC_ID4_DUMMY  4
`define FEC_BLK_MSB    21
`define FEC_BLK_LSB    16

// ==========================================================
// Timing
`define FEC_CLK_NS     25
`define FEC_SCK_HALF   4
`define FEC_CS_GAP     4
`define FEC_T_DP_NS    3000
`define FEC_T_RES1_NS  3000
`define FEC_T_RES2_NS  20000
`define FEC_BE_MS      150
`define FEC_CE_MS      10000
`define FEC_DP_CYC     (`FEC_T_DP_NS / `FEC_CLK_NS)
`define FEC_RES1_CYC   ((`FEC_T_RES1_NS + `FEC_CLK_NS - 1) / `FEC_CLK_NS)
`define FEC_RES2_CYC   ((`FEC_T_RES2_NS + `FEC_CLK_NS - 1) / `FEC_CLK_NS)
`define FEC_BE_CYC     ((`FEC_BE_MS * 64'd1000000) / `FEC_CLK_NS)
`define FEC_CE_CYC     ((`FEC_CE_MS * 64'd1000000) / `FEC_CLK_NS)

`endif

// ### verilog/fec_pkg.sv
// Types shared by both ends of the serial flash command link.
// Assumes fec_defs.svh is on the include path.
`include "fec_defs.svh"

package fec_pkg;

  // ========================================================
  // Device frame phase
  typedef enum logic [5:0] {
    PH_IDLE = 6'h01,
    PH_OP   = 6'h02,
    PH_ADR  = 6'h04,
    PH_ARM  = 6'h08,
    PH_OUT  = 6'h10,
    PH_IGN  = 6'h20
  } fec_phase_type;

  // Device self-timed activity
  typedef enum logic [3:0] {
    BK_NONE  = 4'h1,
    BK_ERASE = 4'h2,
    BK_SLEEP = 4'h4,
    BK_WAKE  = 4'h8
  } fec_busy_type;

  // Host frame phase
  typedef enum logic [2:0] {
    HP_IDLE = 3'h1,
    HP_RUN  = 3'h2,
    HP_GAP  = 3'h4
  } fec_hphase_type;

  // ========================================================
  // Device state
  typedef struct packed {
    logic [5:0]    s1;
    logic [5:0]    s2;
    logic [1:0]    prev;
    fec_phase_type ph;
    logic [7:0]    op;
    logic [23:0]   adr;
    logic [5:0]    cnt;
    logic [5:0]    len;
    logic [2:0]    w;
    logic [15:0]   sh;
    logic [3:0]    dq;
    logic [3:0]    doe;
    logic          write_permit_latch;
    logic          cycle_active_flag;
    logic          sleep;
    logic          hpm;
    logic          go;
    logic          chip;
    logic [5:0]    blk;
    fec_busy_type  busy;
    logic [31:0]   tmr;
  } fec_dev_st_type;

  // Host state
  typedef struct packed {
    logic [3:0]     s1;
    logic [3:0]     s2;
    fec_hphase_type ph;
    logic           pre;
    logic [7:0]     op;
    logic [23:0]    adr;
    logic           aen;
    logic [7:0]     rd;
    logic [2:0]     w;
    logic [31:0]    tx;
    logic [7:0]     k;
    logic [7:0]     txe;
    logic [7:0]     rxb;
    logic [7:0]     tot;
    logic [2:0]     dv;
    logic           sck;
    logic           cs_n;
    logic [3:0]     hio;
    logic [3:0]     hoe;
    logic [15:0]    gap;
    logic           busy;
    logic           done;
    logic [15:0]    rdata;
  } fec_host_st_type;

endpackage

// ### verilog/fec_if.sv
// Serial flash link: select, clock and four data lanes.
// Lanes idle high, as with pull-ups on the board.
`timescale 1ns/1ps
`default_nettype none

interface fec_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] h_io;
  logic [3:0] h_oe;
  logic [3:0] d_io;
  logic [3:0] d_oe;
  logic [3:0] io;

  // ========================================================
  // Wire level from the two drivers, pulled high when free
  assign io = (h_oe & h_io) | (d_oe & d_io) | ~(h_oe | d_oe);

  modport host (output cs_n, output sclk, output h_io, output h_oe,
                input io);
  modport dev  (input cs_n, input sclk, input io,
                output d_io, output d_oe);
endinterface

`default_nettype wire

// ### verilog/fec_host.sv
// Controller end: frames one command on the serial link per request, two for erases.
// Makes the serial clock from the system clock by a divider.
`timescale 1ns/1ps
`default_nettype none
`include "fec_defs.svh"

module fec_host
  import fec_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  fec_if.host              bus,
  input  wire logic        start_i,
  input  wire logic [7:0]  op_i,
  input  wire logic [23:0] addr_i,
  input  wire logic        addr_en_i,
  input  wire logic [7:0]  rd_clks_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [15:0]      rdata_o
);

  fec_host_st_type s_q;
  fec_host_st_type s_d;

  // ========================================================
  // Frame setup: opcode on one lane, then address and dummies
  function automatic fec_host_st_type ld(input fec_host_st_type x,
                                         input logic [7:0]      o,
                                         input logic            a,
                                         input logic [7:0]      r);
    fec_host_st_type y;
    y      = x;
    y.w    = (o == `FEC_OP_ID4) ? 3'd4 : (o == `FEC_OP_ID2) ? 3'd2 : 3'd1;
    y.txe  = a ? 8'(`FEC_OP_BITS + `FEC_ADR_BITS / y.w) : 8'(`FEC_OP_BITS);
    y.rxb  = (o == `FEC_OP_ID4) ? y.txe + 8'(`FEC_ID4_DUMMY) : y.txe;
    y.tot  = y.rxb + r;
    y.tx   = {o, x.adr};
    y.k    = 8'd0;
    y.dv   = 3'd0;
    y.ph   = HP_RUN;
    y.cs_n = 1'b0;
    y.hio  = {3'b000, o[7]};
    y.hoe  = 4'h1;
    // Hold-off after the frame; wakes need the release delay
    if (o == `FEC_OP_WAKE)
      y.gap = (r == 8'd0) ? 16'(`FEC_RES1_CYC)
                          : 16'(`FEC_RES2_CYC);
    else
      y.gap = 16'(`FEC_CS_GAP);
    return y;
  endfunction

  logic [2:0]  wk;
  logic [2:0]  wn;
  logic [31:0] txn;

  // ========================================================
  // Next-state logic
  always_comb begin
    s_d      = s_q;
    s_d.s1   = bus.io;
    s_d.s2   = s_q.s1;
    s_d.done = 1'b0;
    wk  = (s_q.k < 8'(`FEC_OP_BITS)) ? 3'd1 : s_q.w;
    wn  = (s_q.k + 8'd1 < 8'(`FEC_OP_BITS)) ? 3'd1 : s_q.w;
    txn = s_q.tx << wk;
    case (s_q.ph)
      HP_IDLE: begin
        if (start_i) begin
          s_d.op   = op_i;
          s_d.adr  = addr_i;
          s_d.aen  = addr_en_i;
          s_d.rd   = rd_clks_i;
          s_d.busy = 1'b1;
          // Erases get a write permit frame first
          s_d.pre  = (op_i == `FEC_OP_BLK || op_i == `FEC_OP_CHIP_A ||
                      op_i == `FEC_OP_CHIP_B);
          s_d.adr  = addr_i;
          if (s_d.pre)
            s_d = ld(s_d, `FEC_OP_WRITE_PERMIT_CMD, 1'b0, 8'd0);
          else
            s_d = ld(s_d, op_i, addr_en_i, rd_clks_i);
        end
      end
      HP_RUN: begin
        s_d.dv = s_q.dv + 3'd1;
        if (s_q.dv == 3'(`FEC_SCK_HALF - 1)) begin
          s_d.dv  = 3'd0;
          s_d.sck = ~s_q.sck;
          if (s_q.sck) begin
            // Falling edge: capture read lanes, then next slot
            if (s_q.k >= s_q.rxb) begin
              case (s_q.w)
                3'd4:    s_d.rdata = {s_q.rdata[11:0], s_q.s2};
                3'd2:    s_d.rdata = {s_q.rdata[13:0], s_q.s2[1:0]};
                default: s_d.rdata = {s_q.rdata[14:0], s_q.s2[1]};
              endcase
            end
            s_d.k  = s_q.k + 8'd1;
            s_d.tx = txn;
            if (s_q.k + 8'd1 == s_q.tot) begin
              s_d.ph   = HP_GAP;
              s_d.cs_n = 1'b1;
              s_d.hoe  = 4'h0;
            end else if (s_q.k + 8'd1 < s_q.txe) begin
              case (wn)
                3'd4: begin
                  s_d.hio = txn[31:28];
                  s_d.hoe = 4'hf;
                end
                3'd2: begin
                  s_d.hio = {2'b00, txn[31:30]};
                  s_d.hoe = 4'h3;
                end
                default: begin
                  s_d.hio = {3'b000, txn[31]};
                  s_d.hoe = 4'h1;
                end
              endcase
            end else begin
              s_d.hoe = 4'h0;
            end
          end
        end
      end
      default: begin
        // Select held high for the whole hold-off
        if (s_q.gap <= 16'd1) begin
          if (s_q.pre) begin
            s_d.pre = 1'b0;
            s_d = ld(s_d, s_q.op, s_q.aen, s_q.rd);
          end else begin
            s_d.ph   = HP_IDLE;
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
          end
        end else begin
          s_d.gap = s_q.gap - 16'd1;
        end
      end
    endcase
  end

  // ========================================================
  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q      <= '0;
      s_q.s1   <= 4'hf;
      s_q.s2   <= 4'hf;
      s_q.ph   <= HP_IDLE;
      s_q.cs_n <= 1'b1;
      s_q.w    <= 3'd1;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================
  // Outputs straight from the state register
  assign bus.cs_n = s_q.cs_n;
  assign bus.sclk = s_q.sck;
  assign bus.h_io = s_q.hio;
  assign bus.h_oe = s_q.hoe;
  assign busy_o   = s_q.busy;
  assign done_o   = s_q.done;
  assign rdata_o  = s_q.rdata;

endmodule

`default_nettype wire

// ### test/fec_props.sv
// Link and status checks for one host/device pair of the flash link.
// Assumes the link signals and device status come from one pair.
`timescale 1ns/1ps
`default_nettype none

module fec_props (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_oe,
  input wire logic       cycle_active_flag_o,
  input wire logic       write_permit_latch_o,
  input wire logic       deep_sleep_o,
  input wire logic       erase_start_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // Erase launch steps: start seen with select high, then busy
  sequence launch_s;
    erase_start_o ##0 cs_n;
  endsequence
  sequence busy_s;
    cycle_active_flag_o [*8];
  endsequence

  // ==========================================================
  // Wire rules
  clk_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  lane_free_a: assert property (cs_n [*5] |-> d_oe == 4'h0)
    else $error("device drives a lane while deselected");
  // Both ends driving one lane would hide the read data
  no_fight_a: assert property ((h_oe & d_oe) == 4'h0)
    else $error("host and device drive the same lane");

  // ==========================================================
  // Erase and sleep rules
  erase_pulse_a: assert property (erase_start_o |=> !erase_start_o)
    else $error("erase start longer than one cycle");
  erase_state_a: assert property (launch_s |->
    cycle_active_flag_o && !write_permit_latch_o)
    else $error("erase start without busy flag or with latch");
  erase_sel_a: assert property (erase_start_o |-> cs_n)
    else $error("erase started while selected");
  erase_permit_a: assert property (erase_start_o |->
    $past(write_permit_latch_o))
    else $error("erase started with latch clear");
  erase_len_a: assert property ($rose(cycle_active_flag_o) |-> busy_s)
    else $error("busy flag dropped too soon");
  sleep_idle_a: assert property ($rose(deep_sleep_o) |->
    !cycle_active_flag_o && cs_n)
    else $error("deep sleep entered during a cycle");
  sleep_quiet_a: assert property (deep_sleep_o |-> !erase_start_o)
    else $error("erase started in deep sleep");
endmodule

`default_nettype wire

// ### test/tb_flash_erase_powerdown_id_cmds.sv
// Self-checking bench: host and device joined over the link.
// Assumes design files and fec_props are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end

module tb_flash_erase_powerdown_id_cmds;
  import fec_pkg::*;
  localparam logic [7:0] MID = 8'h5a; // Arbitrary value
  localparam logic [7:0] DID = 8'h3c; // Arbitrary value
  logic        clk_sys_i, rst_n_i, start_i, addr_en_i, hpm_set_i, prot_cmp;
  logic        busy_o, done_o, erase_chip_o, flag, latch, sleep, hpm, est;
  logic        chip_seen;
  logic [7:0]  op_i, rd_clks_i;
  logic [7:0]  wk [3] = '{8'hab, 8'h66, 8'h99};
  logic [23:0] addr_i;
  logic [15:0] rdata_o;
  logic [5:0]  erase_block_o, blk_seen;
  logic [4:0]  prot_sel;
  int          miscompares, checked, n_erase;

  // ==========================================================
  // Clock, pair under test and checker
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  fec_if lnk ();
  fec_host fec_host_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus(lnk),
    .start_i(start_i), .op_i(op_i), .addr_i(addr_i), .addr_en_i(addr_en_i),
    .rd_clks_i(rd_clks_i), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o));
  // Short chip erase; block erase long enough to overlap two frames
  fec_dev #(.BE_CYC(32'd1000), .CE_CYC(32'd80), .MAKER_ID(MID),
    .DEVICE_ID(DID)) fec_dev_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .bus(lnk), .protect_sel_i(prot_sel), .protect_complement_i(prot_cmp),
    .hpm_set_i(hpm_set_i), .cycle_active_flag_o(flag),
    .write_permit_latch_o(latch), .deep_sleep_o(sleep), .high_perf_o(hpm),
    .erase_start_o(est), .erase_chip_o(erase_chip_o),
    .erase_block_o(erase_block_o));
  fec_props fec_props_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .cs_n(lnk.cs_n), .sclk(lnk.sclk), .h_oe(lnk.h_oe), .d_oe(lnk.d_oe),
    .cycle_active_flag_o(flag), .write_permit_latch_o(latch),
    .deep_sleep_o(sleep), .erase_start_o(est));

  // Erase launches counted, since the pulse lasts one cycle
  always @(negedge clk_sys_i) begin
    if (est === 1'b1) begin
      n_erase++;
      blk_seen = erase_block_o;
      chip_seen = erase_chip_o;
    end
  end

  // ==========================================================
  // Tasks
  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One host request; done sampled mid-cycle to avoid edge races
  task automatic cmd(input logic [7:0] o, input logic [23:0] a,
                     input logic e, input logic [7:0] r);
    int n;
    @(posedge clk_sys_i);
    start_i <= 1'b1;
    op_i <= o;
    addr_i <= a;
    addr_en_i <= e;
    rd_clks_i <= r;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    @(negedge clk_sys_i);
    `CHK(busy_o, 1'b1)
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (done_o !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      miscompares++;
      $display("[FAIL] %0t host never finished", $time);
    end
    `CHK(busy_o, 1'b0)
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (flag !== 1'b0 && n < 2000) begin
      @(negedge clk_sys_i);
      n++;
    end
    `CHK(flag, 1'b0)
  endtask

  // ==========================================================
  // Tests
  initial begin
    rst_n_i = 1'b0;
    start_i = 1'b0;
    op_i = 8'h00;
    addr_i = 24'h000000;
    addr_en_i = 1'b0;
    rd_clks_i = 8'h00;
    hpm_set_i = 1'b0;
    prot_sel = 5'h00;
    prot_cmp = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(negedge clk_sys_i);
    `CHK({flag, latch, sleep, hpm, est}, 5'h00)
    cmd(8'h90, 24'h000000, 1'b1, 8'h10);
    `CHK(rdata_o, {MID, DID})
    cmd(8'h92, 24'h000000, 1'b1, 8'h08);
    `CHK(rdata_o, {MID, DID})
    cmd(8'h94, 24'h000000, 1'b1, 8'h04);
    `CHK(rdata_o, {MID, DID})
    cmd(8'hab, 24'h000000, 1'b1, 8'h10);
    `CHK(rdata_o, {DID, DID})
    $display("test id reads over");
    cmd(8'hd8, 24'h05a5a5, 1'b1, 8'h00);
    `CHK({n_erase, blk_seen, chip_seen, latch}, {32'd1, 6'h05, 2'b00})
    cmd(8'hb9, 24'h000000, 1'b0, 8'h00);
    cmd(8'hab, 24'h000000, 1'b1, 8'h10);
    `CHK(rdata_o, 16'hffff)
    `CHK(sleep, 1'b0)
    wait_idle();
    @(posedge clk_sys_i);
    prot_sel <= 5'h01;
    cmd(8'hd8, 24'h3f0000, 1'b1, 8'h00);
    cmd(8'h60, 24'h000000, 1'b0, 8'h00);
    `CHK(n_erase, 1)
    cmd(8'hd8, 24'h00ffff, 1'b1, 8'h00);
    `CHK({n_erase, blk_seen}, {32'd2, 6'h00})
    wait_idle();
    @(posedge clk_sys_i);
    prot_sel <= 5'h07;
    prot_cmp <= 1'b1;
    cmd(8'h60, 24'h000000, 1'b0, 8'h00);
    `CHK({n_erase, chip_seen}, {32'd3, 1'b1})
    wait_idle();
    @(posedge clk_sys_i);
    prot_sel <= 5'h00;
    prot_cmp <= 1'b0;
    cmd(8'hc7, 24'h000000, 1'b0, 8'h00);
    wait_idle();
    cmd(8'hd8, 24'h000000, 1'b0, 8'h00);
    cmd(8'h60, 24'h000000, 1'b1, 8'h00);
    `CHK(n_erase, 4)
    $display("test erase over");
    foreach (wk[i]) begin
      cmd(8'hb9, 24'h000000, 1'b0, 8'h00);
      repeat (150) @(negedge clk_sys_i);
      `CHK(sleep, 1'b1)
      cmd(8'h90, 24'h000000, 1'b1, 8'h10);
      `CHK(rdata_o, 16'hffff)
      cmd(wk[i], 24'h000000, 1'b0, 8'h00);
      repeat (150) @(negedge clk_sys_i);
      `CHK(sleep, 1'b0)
    end
    // Wake by the ID-reading form: ID served, longer hold-off
    cmd(8'hb9, 24'h000000, 1'b0, 8'h00);
    repeat (150) @(negedge clk_sys_i);
    cmd(8'hab, 24'h000000, 1'b1, 8'h10);
    `CHK({rdata_o, sleep}, {DID, DID, 1'b0})
    @(posedge clk_sys_i);
    hpm_set_i <= 1'b1;
    @(posedge clk_sys_i);
    hpm_set_i <= 1'b0;
    @(negedge clk_sys_i);
    `CHK(hpm, 1'b1)
    cmd(8'hab, 24'h000000, 1'b0, 8'h00);
    `CHK(hpm, 1'b0)
    $display("test sleep over");
    complete_run();
  end

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    miscompares++;
    complete_run();
  end
endmodule

`default_nettype wire
